// ---- design/mqaf_top.sv ----
// Per-queue almost-full, almost-empty and output-valid tracking with an APB register file.
//
// Behaviour
// - Almost-full pin shows selected write queue only
// - Almost-full status kept for every queue
// - Offsets programmed, or default 8 or 128
// - Each queue own almost-full offset m
// - New write queue status on second edge
// - Almost-full falls two cycles after write
// - Read releases almost-full after crossing stage
// - Almost-full changes only on clock edge
// - Reads update almost-full of read queue
// - Almost-full copied onto eight-bit status bus
// - Almost-empty pin shows selected read queue
// - Almost-empty status kept for every queue
// - Each queue own almost-empty offset n
// - New read queue status on second edge
// - Almost-empty falls two cycles after read
// - Write releases almost-empty after crossing stage
// - Almost-empty changes only on clock edge
// - Writes update almost-empty of write queue
// - Almost-empty copied onto eight-bit status bus
// - Output valid tracks word in output register
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module mqaf_top
   import mqaf_pkg::*;
#(
   parameter int unsigned NQ    = QCOUNT,
   parameter int unsigned DEPTH = QDEPTH,
   parameter int unsigned QW    = $clog2(NQ)
) (
   // Clock and reset
   input  wire logic          pclk,
   input  wire logic          presetn,
   // APB slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   // Write port
   input  wire logic [QW-1:0] wr_queue_addr,
   input  wire logic          wr_addr_en,
   input  wire logic          wr_en,
   // Read port
   input  wire logic [QW-1:0] rd_queue_addr,
   input  wire logic          rd_addr_en,
   input  wire logic          rd_en,
   // Flags
   output logic               almost_full_n,
   output logic               almost_empty_n,
   output logic               out_valid_n,
   output logic [BUS_W-1:0]   almost_full_status_bus,
   output logic [BUS_W-1:0]   almost_empty_status_bus
);

   // ********************************************************************
   // State
   // ********************************************************************
   // Counts are kept in nine-bit units so every bus matching setup shares one scale.
   localparam int unsigned CW  = $clog2(2 * DEPTH + 1);
   localparam logic [CW-1:0] CAP   = CW'(2 * DEPTH);
   localparam logic [CW-1:0] U_ONE = CW'(1);
   localparam logic [CW-1:0] U_TWO = CW'(2);

   typedef struct packed {
      logic [NQ-1:0][CW-1:0] cnt;
      logic [NQ-1:0][CW-1:0] af_ofs;
      logic [NQ-1:0][CW-1:0] ae_ofs;
      logic [NQ-1:0]         af_q;
      logic [NQ-1:0]         ae_q;
      logic [QW-1:0]         wpend;
      logic [QW-1:0]         wsel;
      logic [QW-1:0]         rpend;
      logic [QW-1:0]         rsel;
      logic                  def_prog;
      logic                  def_big;
      logic [1:0]            mode;
      logic                  almost_full_n;
      logic                  almost_empty_n;
      logic                  out_valid_n;
      logic [BUS_W-1:0]      af_bus;
      logic [BUS_W-1:0]      ae_bus;
      logic [31:0]           prdata;
      logic                  pready;
      logic                  pslverr;
   } mqaf_state_t;

   mqaf_state_t           s_r;
   mqaf_state_t           s_nxt;
   logic [NQ-1:0][CW-1:0] m_eff;
   logic [NQ-1:0][CW-1:0] n_eff;
   logic [NQ-1:0]         af_c;
   logic [NQ-1:0]         ae_c;
   logic [CW-1:0]         wunit;
   logic [CW-1:0]         runit;
   logic                  wide_in;
   logic                  wide_out;
   logic                  wr_go;
   logic                  rd_go;
   logic [CW-1:0]         cval;
   logic [CW:0]           thr;
   logic [31:0]           rd_val;
   logic                  bad_addr;
   logic                  setup;
   logic                  wr_acc;
   logic [5:0]            idx;
   logic                  idx_ok;
   logic [CW-1:0]         def_ofs;
   int                    gq;

   // ********************************************************************
   // Next-state logic
   // ********************************************************************
   // One process computes every next value; the flop stage below is the only storage.
   always_comb begin
      s_nxt    = s_r;
      cval     = '0;
      thr      = '0;
      gq       = 0;
      wide_in  = (s_r.mode == MQAF_W18_R18) || (s_r.mode == MQAF_W18_R9);
      wide_out = (s_r.mode == MQAF_W18_R18) || (s_r.mode == MQAF_W9_R18);
      wunit    = wide_in ? U_TWO : U_ONE;
      runit    = wide_out ? U_TWO : U_ONE;
      def_ofs  = s_r.def_big ? CW'(DEF_OFS_BIG) : CW'(DEF_OFS_SMALL);

      // Offsets in force: programmed per queue, or the common default.
      for (int q = 0; q < NQ; q++) begin
         m_eff[q] = s_r.def_prog ? def_ofs : s_r.af_ofs[q];
         n_eff[q] = s_r.def_prog ? def_ofs : s_r.ae_ofs[q];
      end

      // A write needs room for a whole input word, a read a whole output word.
      wr_go = wr_en && ((CAP - s_r.cnt[s_r.wsel]) >= wunit);
      rd_go = rd_en && (s_r.cnt[s_r.rsel] >= runit);

      // Each port acts only on the count of its selected queue, so inactive queues hold their counts.
      for (int q = 0; q < NQ; q++) begin
         cval = s_r.cnt[q];
         if (wr_go && (s_r.wsel == QW'(q))) begin
            cval = cval + wunit;
         end
         if (rd_go && (s_r.rsel == QW'(q))) begin
            cval = cval - runit;
         end
         s_nxt.cnt[q] = cval;
      end

      // Per-queue status from the counts; offsets are counted in port words.
      for (int q = 0; q < NQ; q++) begin
         thr     = wide_in ? {m_eff[q], 1'b0} : {1'b0, m_eff[q]};
         af_c[q] = {1'b0, CAP - s_r.cnt[q]} <= thr;
         thr     = wide_out ? {n_eff[q], 1'b0} : {1'b0, n_eff[q]};
         ae_c[q] = {1'b0, s_r.cnt[q]} <= thr;
      end
      // This stage is the crossing register between the two ports' views.
      s_nxt.af_q = af_c;
      s_nxt.ae_q = ae_c;

      // Queue selection takes effect one edge after it is presented.
      if (wr_addr_en) begin
         s_nxt.wpend = wr_queue_addr;
      end
      s_nxt.wsel = s_r.wpend;
      if (rd_addr_en) begin
         s_nxt.rpend = rd_queue_addr;
      end
      s_nxt.rsel = s_r.rpend;

      // Second register of each flag, so status shows two edges after its cause.
      s_nxt.almost_full_n  = !s_r.af_q[s_r.wsel];
      s_nxt.almost_empty_n = !s_r.ae_q[s_r.rsel];
      // Nine-to-eighteen needs two units before an output word exists.
      s_nxt.out_valid_n    = !(s_r.cnt[s_r.rsel] >= runit);

      // Status buses show the group of eight holding the active queue.
      for (int i = 0; i < BUS_W; i++) begin
         gq = int'(s_r.wsel) - (int'(s_r.wsel) % BUS_W) + i;
         s_nxt.af_bus[i] = (gq < NQ) ? !s_r.af_q[gq] : 1'b1;
         gq = int'(s_r.rsel) - (int'(s_r.rsel) % BUS_W) + i;
         s_nxt.ae_bus[i] = (gq < NQ) ? !s_r.ae_q[gq] : 1'b0;
      end

      // APB decode. The answer is prepared in the setup cycle so every output stays a flop.
      setup    = psel && !penable;
      wr_acc   = psel && penable && s_r.pready && pwrite && !s_r.pslverr;
      idx      = paddr[IDX_HI:IDX_LO];
      idx_ok   = (int'(idx) < NQ) && (paddr[1:0] == 2'b00);
      rd_val   = '0;
      bad_addr = 1'b0;
      if (paddr == REG_CTRL) begin
         rd_val[CTRL_DEF_BIT]                 = s_r.def_prog;
         rd_val[CTRL_BIG_BIT]                 = s_r.def_big;
         rd_val[CTRL_MODE_LSB +: 2]           = s_r.mode;
      end else if (paddr == REG_STATUS) begin
         rd_val[NQ-1:0]                       = s_r.af_q;
         rd_val[STAT_AE_LSB +: NQ]            = s_r.ae_q;
      end else if (idx_ok && (paddr[PAGE_HI:PAGE_LO] == REG_AF_BASE[PAGE_HI:PAGE_LO])) begin
         rd_val[CW-1:0]                       = s_r.af_ofs[idx];
      end else if (idx_ok && (paddr[PAGE_HI:PAGE_LO] == REG_AE_BASE[PAGE_HI:PAGE_LO])) begin
         rd_val[CW-1:0]                       = s_r.ae_ofs[idx];
      end else if (idx_ok && (paddr[PAGE_HI:PAGE_LO] == REG_CNT_BASE[PAGE_HI:PAGE_LO])) begin
         rd_val[CW-1:0]                       = s_r.cnt[idx];
      end else begin
         bad_addr = 1'b1;
      end
      s_nxt.pready  = setup;
      s_nxt.pslverr = setup && bad_addr;
      if (setup) begin
         s_nxt.prdata = rd_val;
      end

      // Register writes land only at the completing access edge.
      if (wr_acc) begin
         if (paddr == REG_CTRL) begin
            s_nxt.def_prog = pwdata[CTRL_DEF_BIT];
            s_nxt.def_big  = pwdata[CTRL_BIG_BIT];
            s_nxt.mode     = pwdata[CTRL_MODE_LSB +: 2];
         end else if (idx_ok && (paddr[PAGE_HI:PAGE_LO] == REG_AF_BASE[PAGE_HI:PAGE_LO])) begin
            s_nxt.af_ofs[idx] = pwdata[CW-1:0];
         end else if (idx_ok && (paddr[PAGE_HI:PAGE_LO] == REG_AE_BASE[PAGE_HI:PAGE_LO])) begin
            s_nxt.ae_ofs[idx] = pwdata[CW-1:0];
         end
      end
   end

   // ********************************************************************
   // State register
   // ********************************************************************
   // Reset leaves all queues empty: not almost full, almost empty, no valid word.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r                <= '0;
         s_r.ae_q           <= '1;
         s_r.def_prog       <= CTRL_DEF_RST;
         s_r.def_big        <= CTRL_BIG_RST;
         s_r.almost_full_n  <= 1'b1;
         s_r.out_valid_n    <= 1'b1;
         s_r.af_bus         <= '1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs come straight from the state register.
   assign prdata                  = s_r.prdata;
   assign pready                  = s_r.pready;
   assign pslverr                 = s_r.pslverr;
   assign almost_full_n           = s_r.almost_full_n;
   assign almost_empty_n          = s_r.almost_empty_n;
   assign out_valid_n             = s_r.out_valid_n;
   assign almost_full_status_bus  = s_r.af_bus;
   assign almost_empty_status_bus = s_r.ae_bus;

   // ********************************************************************
   // Assertions
   // ********************************************************************
   property p_af_active;
      @(posedge pclk) disable iff (!presetn)
      1 |=> almost_full_n == !$past(s_r.af_q[s_r.wsel]);
   endproperty
   a_af_active: assert property (p_af_active) else $error("almost_full_n not from active queue");

   property p_wsel;
      @(posedge pclk) disable iff (!presetn)
      wr_addr_en |=> ##1 s_r.wsel == $past(wr_queue_addr, 2);
   endproperty
   a_wsel: assert property (p_wsel) else $error("write queue switch late");

   property p_af_two;
      @(posedge pclk) disable iff (!presetn)
      (af_c[s_r.wsel] && !$changed(s_r.wsel) && !$changed(s_r.wpend)) |=> ##1 !almost_full_n;
   endproperty
   a_af_two: assert property (p_af_two) else $error("almost_full_n not low two edges on");

   property p_rsel;
      @(posedge pclk) disable iff (!presetn)
      rd_addr_en |=> ##1 s_r.rsel == $past(rd_queue_addr, 2);
   endproperty
   a_rsel: assert property (p_rsel) else $error("read queue switch late");

   property p_ae_two;
      @(posedge pclk) disable iff (!presetn)
      (ae_c[s_r.rsel] && !$changed(s_r.rsel) && !$changed(s_r.rpend)) |=> ##1 !almost_empty_n;
   endproperty
   a_ae_two: assert property (p_ae_two) else $error("almost_empty_n not low two edges on");

   property p_bus_af;
      @(posedge pclk) disable iff (!presetn)
      1 |=> almost_full_status_bus[$past(s_r.wsel) % BUS_W] == almost_full_n;
   endproperty
   a_bus_af: assert property (p_bus_af) else $error("status bus disagrees with almost_full_n");

   property p_bus_ae;
      @(posedge pclk) disable iff (!presetn)
      1 |=> almost_empty_status_bus[$past(s_r.rsel) % BUS_W] == almost_empty_n;
   endproperty
   a_bus_ae: assert property (p_bus_ae) else $error("status bus disagrees with almost_empty_n");

   property p_cnt_wr;
      @(posedge pclk) disable iff (!presetn)
      (wr_go && !(rd_go && s_r.rsel == s_r.wsel)) |=> s_r.cnt[$past(s_r.wsel)] == $past(s_r.cnt[s_r.wsel] + wunit);
   endproperty
   a_cnt_wr: assert property (p_cnt_wr) else $error("write did not raise queue count");

   property p_cnt_rd;
      @(posedge pclk) disable iff (!presetn)
      (rd_go && !(wr_go && s_r.rsel == s_r.wsel)) |=> s_r.cnt[$past(s_r.rsel)] == $past(s_r.cnt[s_r.rsel] - runit);
   endproperty
   a_cnt_rd: assert property (p_cnt_rd) else $error("read did not lower queue count");

   property p_def_ofs;
      @(posedge pclk) disable iff (!presetn)
      s_r.def_prog |-> (m_eff[0] == CW'(DEF_OFS_SMALL)) || (m_eff[0] == CW'(DEF_OFS_BIG));
   endproperty
   a_def_ofs: assert property (p_def_ofs) else $error("default offset not 8 or 128");

   property p_out_valid;
      @(posedge pclk) disable iff (!presetn)
      1 |=> out_valid_n == ($past(s_r.cnt[s_r.rsel]) < $past(runit));
   endproperty
   a_out_valid: assert property (p_out_valid) else $error("out_valid_n wrong for output word");

   property p_ae_active;
      @(posedge pclk) disable iff (!presetn)
      1 |=> almost_empty_n == !$past(s_r.ae_q[s_r.rsel]);
   endproperty
   a_ae_active: assert property (p_ae_active) else $error("almost_empty_n not from active queue");

   // Releases take the same two edges as assertions, since both pass the status stage.
   property p_af_rel;
      @(posedge pclk) disable iff (!presetn)
      (!af_c[s_r.wsel] && !$changed(s_r.wsel) && !$changed(s_r.wpend)) |=> ##1 almost_full_n;
   endproperty
   a_af_rel: assert property (p_af_rel) else $error("almost_full_n not released two edges on");

   property p_ae_rel;
      @(posedge pclk) disable iff (!presetn)
      (!ae_c[s_r.rsel] && !$changed(s_r.rsel) && !$changed(s_r.rpend)) |=> ##1 almost_empty_n;
   endproperty
   a_ae_rel: assert property (p_ae_rel) else $error("almost_empty_n not released two edges on");

   // Counts move only with a port strobe, and a refused operation never wraps them.
   property p_cnt_hold;
      @(posedge pclk) disable iff (!presetn)
      (!wr_en && !rd_en) |=> s_r.cnt == $past(s_r.cnt);
   endproperty
   a_cnt_hold: assert property (p_cnt_hold) else $error("queue count moved without a strobe");

   property p_cnt_cap;
      @(posedge pclk) disable iff (!presetn)
      1 |-> (s_r.cnt[s_r.wsel] <= CAP) && (s_r.cnt[s_r.rsel] <= CAP);
   endproperty
   a_cnt_cap: assert property (p_cnt_cap) else $error("queue count beyond capacity");

   // A pending selection changes only when the controller presents a new one.
   property p_wpend_hold;
      @(posedge pclk) disable iff (!presetn)
      !wr_addr_en |=> s_r.wpend == $past(s_r.wpend);
   endproperty
   a_wpend_hold: assert property (p_wpend_hold) else $error("write selection moved without enable");

   property p_rpend_hold;
      @(posedge pclk) disable iff (!presetn)
      !rd_addr_en |=> s_r.rpend == $past(s_r.rpend);
   endproperty
   a_rpend_hold: assert property (p_rpend_hold) else $error("read selection moved without enable");

   property p_valid_empty;
      @(posedge pclk) disable iff (!presetn)
      (s_r.cnt[s_r.rsel] == '0) |=> out_valid_n;
   endproperty
   a_valid_empty: assert property (p_valid_empty) else $error("empty queue shows a valid word");

endmodule

// ---- pkg/mqaf_pkg.sv ----
// Constants, register map and encodings of the multi-queue almost-flag block.
package mqaf_pkg;

   // ********************************************************************
   // Sizes
   // ********************************************************************
   localparam int unsigned QCOUNT       = 8;
   localparam int unsigned QDEPTH       = 2048;
   localparam int unsigned BUS_W        = 8;
   localparam int unsigned DEF_OFS_SMALL = 8;
   localparam int unsigned DEF_OFS_BIG   = 128;

   // ********************************************************************
   // Register map, byte addresses on APB
   // ********************************************************************
   localparam logic [11:0] REG_CTRL     = 12'h000;
   localparam logic [11:0] REG_STATUS   = 12'h004;
   localparam logic [11:0] REG_AF_BASE  = 12'h100;
   localparam logic [11:0] REG_AE_BASE  = 12'h200;
   localparam logic [11:0] REG_CNT_BASE = 12'h300;
   localparam int unsigned PAGE_HI      = 11;
   localparam int unsigned PAGE_LO      = 8;
   localparam int unsigned IDX_HI       = 7;
   localparam int unsigned IDX_LO       = 2;

   // ********************************************************************
   // Field layout
   // ********************************************************************
   localparam int unsigned CTRL_DEF_BIT  = 0;
   localparam int unsigned CTRL_BIG_BIT  = 1;
   localparam int unsigned CTRL_MODE_LSB = 2;
   localparam int unsigned STAT_AE_LSB   = 16;
   localparam logic        CTRL_DEF_RST  = 1'b1;
   localparam logic        CTRL_BIG_RST  = 1'b0;

   // Bus matching setups, write width to read width.
   typedef enum logic [1:0] {
      MQAF_W18_R18,
      MQAF_W9_R9,
      MQAF_W18_R9,
      MQAF_W9_R18
   } mqaf_mode_t;

endpackage

// ---- sim/mqaf_ctrl_model.sv ----
// System controller model that drives the write and read queue ports of the flag block.
`timescale 1ns/1ns
module mqaf_ctrl_model
   import mqaf_pkg::*;
#(
   parameter int unsigned QW = 3
) (
   // Clock
   input  wire logic          pclk,
   // Write port
   output logic [QW-1:0]      wr_queue_addr,
   output logic               wr_addr_en,
   output logic               wr_en,
   // Read port
   output logic [QW-1:0]      rd_queue_addr,
   output logic               rd_addr_en,
   output logic               rd_en
);
   // ********************************************************************
   // Port cycles
   // ********************************************************************
   // Both ports start idle so that no select or strobe is seen during reset.
   initial begin
      wr_queue_addr = '0;
      wr_addr_en    = 1'b0;
      wr_en         = 1'b0;
      rd_queue_addr = '0;
      rd_addr_en    = 1'b0;
      rd_en         = 1'b0;
   end

   // Queue select for one edge; the address is then scrambled, since the block must not look at it.
   task automatic sel(input bit rd, input logic [QW-1:0] q);
      @(posedge pclk);
      if (rd) begin
         rd_queue_addr <= q;
         rd_addr_en    <= 1'b1;
      end else begin
         wr_queue_addr <= q;
         wr_addr_en    <= 1'b1;
      end
      @(posedge pclk);
      wr_addr_en    <= 1'b0;
      rd_addr_en    <= 1'b0;
      wr_queue_addr <= ~wr_queue_addr;
      rd_queue_addr <= ~rd_queue_addr;
   endtask

   // A burst of k back-to-back operations; returns on the edge of the last one.
   task automatic op(input bit rd, input int k);
      @(posedge pclk);
      if (rd) rd_en <= 1'b1;
      else wr_en <= 1'b1;
      repeat (k) @(posedge pclk);
      rd_en <= 1'b0;
      wr_en <= 1'b0;
   endtask
endmodule

// ---- sim/tb.sv ----
// Self-checking testbench of the multi-queue almost-flag block.
`timescale 1ns/1ns
module tb
   import mqaf_pkg::*;
;
   // ********************************************************************
   // Signals and instances
   // ********************************************************************
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  wr_queue_addr, rd_queue_addr;
   logic        wr_addr_en, rd_addr_en, wr_en, rd_en;
   logic        almost_full_n, almost_empty_n, out_valid_n;
   logic [7:0]  almost_full_status_bus, almost_empty_status_bus;
   int          n_errors, total_checks;

   mqaf_top mqaf_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .wr_queue_addr, .wr_addr_en, .wr_en, .rd_queue_addr, .rd_addr_en, .rd_en, .almost_full_n,
      .almost_empty_n, .out_valid_n, .almost_full_status_bus, .almost_empty_status_bus);
   mqaf_ctrl_model mqaf_ctrl_model_inst (.pclk, .wr_queue_addr, .wr_addr_en, .wr_en, .rd_queue_addr,
      .rd_addr_en, .rd_en);

   // Free-running 250 MHz clock.
   always #2 pclk = ~pclk;

   // ********************************************************************
   // Shared tasks
   // ********************************************************************
   // Compare four-state values so that an unknown never passes.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; request held until pready is sampled high, bounded wait.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int w;
      w = 0;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         w++;
      end while (pready !== 1'b1 && w < 16);
      if (pready !== 1'b1) begin
         n_errors++;
         $display("MISMATCH t=%0t no pready within the wait limit", $time);
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Let n edges land, then sample away from the edge.
   task automatic ed(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   // ********************************************************************
   // Scenarios
   // ********************************************************************
   // Reset levels, control reset value, unmapped access and offset programming.
   task automatic t_regs;
      chk(almost_full_n, 1'b1);
      chk(almost_empty_n, 1'b0);
      chk(out_valid_n, 1'b1);
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, 12'h008, 32'h0);
      chk(err, 1'b1);
      apb(1'b1, REG_CTRL, 32'h0);
      apb(1'b1, REG_AF_BASE + 12'h008, 32'd2045);
      apb(1'b1, REG_AE_BASE + 12'h004, 32'd2);
      apb(1'b1, REG_AF_BASE, 32'h0);
      apb(1'b0, REG_AF_BASE + 12'h008, 32'h0);
      chk(rd, 32'd2045);
   endtask

   // Queue 2 reaches its boundary after three words; switches and reads move the flag.
   task automatic t_full;
      mqaf_ctrl_model_inst.sel(1'b0, 3'd2);
      mqaf_ctrl_model_inst.op(1'b0, 2);
      ed(2);
      chk(almost_full_n, 1'b1);
      mqaf_ctrl_model_inst.op(1'b0, 1);
      ed(1);
      chk(almost_full_n, 1'b1);
      ed(1);
      chk(almost_full_n, 1'b0);
      chk(almost_full_status_bus, 8'hfb);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd[2], 1'b1);
      chk(rd[STAT_AE_LSB+2], 1'b0);
      mqaf_ctrl_model_inst.sel(1'b0, 3'd0);
      ed(1);
      chk(almost_full_n, 1'b0);
      ed(1);
      chk(almost_full_n, 1'b1);
      mqaf_ctrl_model_inst.sel(1'b1, 3'd2);
      mqaf_ctrl_model_inst.op(1'b1, 1);
      ed(2);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd[2], 1'b0);
      mqaf_ctrl_model_inst.sel(1'b0, 3'd2);
      ed(2);
      chk(almost_full_n, 1'b1);
      mqaf_ctrl_model_inst.op(1'b0, 1);
      ed(2);
      chk(almost_full_n, 1'b0);
      mqaf_ctrl_model_inst.op(1'b1, 1);
      ed(1);
      chk(almost_full_n, 1'b0);
      ed(1);
      chk(almost_full_n, 1'b1);
      apb(1'b0, REG_CNT_BASE + 12'h008, 32'h0);
      chk(rd, 32'd4);
   endtask

   // Queue 1 with offset two: writes lift the flag, one read drops it again.
   task automatic t_empty;
      mqaf_ctrl_model_inst.sel(1'b1, 3'd1);
      ed(2);
      chk(almost_empty_n, 1'b0);
      chk(out_valid_n, 1'b1);
      mqaf_ctrl_model_inst.sel(1'b0, 3'd1);
      mqaf_ctrl_model_inst.op(1'b0, 2);
      ed(2);
      chk(almost_empty_n, 1'b0);
      mqaf_ctrl_model_inst.op(1'b0, 1);
      ed(1);
      chk(almost_empty_n, 1'b0);
      ed(1);
      chk(almost_empty_n, 1'b1);
      chk(out_valid_n, 1'b0);
      chk(almost_empty_status_bus[1], 1'b1);
      mqaf_ctrl_model_inst.op(1'b1, 1);
      ed(1);
      chk(almost_empty_n, 1'b1);
      ed(1);
      chk(almost_empty_n, 1'b0);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd[STAT_AE_LSB+1], 1'b1);
   endtask

   // Default programming with the large offset: 128 words still count as almost empty.
   task automatic t_default;
      apb(1'b1, REG_CTRL, 32'h3);
      mqaf_ctrl_model_inst.sel(1'b1, 3'd7);
      mqaf_ctrl_model_inst.sel(1'b0, 3'd7);
      mqaf_ctrl_model_inst.op(1'b0, 128);
      ed(2);
      chk(almost_empty_n, 1'b0);
      mqaf_ctrl_model_inst.op(1'b0, 1);
      ed(2);
      chk(almost_empty_n, 1'b1);
   endtask

   // Every width setup on a fresh queue: narrow-in, wide-out needs two writes.
   task automatic t_valid;
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, REG_CTRL, 32'(k << CTRL_MODE_LSB));
         mqaf_ctrl_model_inst.sel(1'b1, 3'(3 + k));
         mqaf_ctrl_model_inst.sel(1'b0, 3'(3 + k));
         mqaf_ctrl_model_inst.op(1'b0, 1);
         ed(2);
         chk(out_valid_n, (k == 3));
         mqaf_ctrl_model_inst.op(1'b0, 1);
         ed(2);
         chk(out_valid_n, 1'b0);
      end
   endtask

   // ********************************************************************
   // Run control
   // ********************************************************************
   // Verdict and end of run, reached from the main sequence or the watchdog.
   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Watchdog: the tests need a few hundred cycles, so 50000 means a hang.
   initial begin
      #200000;
      n_errors++;
      summarize();
   end

   // Main sequence: reset for twelve cycles, then the scenarios in order.
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      n_errors = 0;
      total_checks = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      ed(1);
      t_regs();
      t_full();
      t_empty();
      t_default();
      t_valid();
      summarize();
   end
endmodule
